// file: include/reg_lock_defines.svh
`ifndef REG_LOCK_DEFINES_SVH
`define REG_LOCK_DEFINES_SVH

// ==========================================================
// register map
`define LOCK_CTRL_ADDR 32'h5000_0100
`define PROT_REG0_ADDR 32'h5000_0104
`define PROT_REG1_ADDR 32'h5000_0108
`define PROT_REG0_RESET 32'h0000_0000
`define PROT_REG1_RESET 32'h0000_0000

// ==========================================================
// fields and key bytes
`define UNLOCKED_BIT 0
`define KEY_BYTE0 8'h59
`define KEY_BYTE1 8'h16
`define KEY_BYTE2 8'h88

`endif

// file: include/reg_lock_pkg.sv
package reg_lock_pkg;
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_GOT1 = 2'b01,
		KEY_GOT2 = 2'b10
	} key_step_e;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] data;
	} wr_req_s;
endpackage

// file: rtl/key_sequencer.sv
`include "reg_lock_defines.svh"
`default_nettype none

module key_sequencer
	import reg_lock_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire wr_req_s wr,
	output logic unlock_pulse
);
	key_step_e step_r;
	key_step_e step_nxt;

	// ==========================================================
	// key detector
	always_comb begin
		step_nxt = step_r;
		unlock_pulse = 1'b0;
		if (wr.valid) begin
			step_nxt = KEY_IDLE; // (RULE4) (RULE7)
			if (wr.addr == `LOCK_CTRL_ADDR) begin
				case (step_r)
					KEY_IDLE: begin
						if (wr.data[7:0] == `KEY_BYTE0)
							step_nxt = KEY_GOT1; // (RULE3)
					end
					KEY_GOT1: begin
						if (wr.data[7:0] == `KEY_BYTE1)
							step_nxt = KEY_GOT2; // (RULE3)
						else if (wr.data[7:0] == `KEY_BYTE0)
							step_nxt = KEY_GOT1;
					end
					KEY_GOT2: begin
						if (wr.data[7:0] == `KEY_BYTE2)
							unlock_pulse = 1'b1; // (RULE3)
						else if (wr.data[7:0] == `KEY_BYTE0)
							step_nxt = KEY_GOT1;
					end
					default: step_nxt = KEY_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			step_r <= KEY_IDLE;
		else
			step_r <= step_nxt;
	end
endmodule

`default_nettype wire

// file: rtl/register_write_protection_lock.sv
// The APB register port is this design's own decision.
`include "reg_lock_defines.svh"
`default_nettype none

// Overview of operation
// (RULE1) power-on reset leaves registers protected
// (RULE2) protected registers change only when unlocked
// (RULE3) keys 59h 16h 88h unlock protection
// (RULE4) wrong value, order or address aborts
// (RULE5) bit 0 reads one while unlocked
// (RULE6) any lock write while unlocked relocks
// (RULE7) sequence restarts from first key
module register_write_protection_lock
	import reg_lock_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic unlocked,
	output logic [31:0] prot_reg0,
	output logic [31:0] prot_reg1
);
	logic unlocked_r;
	logic [31:0] prot0_r;
	logic [31:0] prot1_r;
	logic [31:0] rdata_r;
	logic slverr_r;
	logic pready_r;
	logic unlock_pulse;
	logic access;
	wr_req_s wr;
	wr_req_s wr_key;

	function automatic logic mapped(input logic [31:0] a);
		mapped = (a == `LOCK_CTRL_ADDR) || (a == `PROT_REG0_ADDR) || (a == `PROT_REG1_ADDR);
	endfunction

	// ==========================================================
	// apb decode: zero wait states, answer in the access cycle
	assign access = psel && penable;
	assign wr = '{valid: access && pwrite, addr: paddr, data: pwdata};
	// data masked while open: relocking writes must not seed a new key sequence
	assign wr_key = '{valid: access && pwrite, addr: paddr, data: (unlocked_r ? 32'h0000_0000 : pwdata)}; // (RULE7)

	// held high in and out of reset; a flop so every output is registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready_r <= 1'b1;
		else
			pready_r <= 1'b1;
	end

	key_sequencer u_keys (
		.pclk(pclk),
		.presetn(presetn),
		.wr(wr_key),
		.unlock_pulse(unlock_pulse)
	);

	// ==========================================================
	// lock state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			unlocked_r <= 1'b0; // (RULE1)
		else if (wr.valid && paddr == `LOCK_CTRL_ADDR) begin
			if (unlocked_r)
				unlocked_r <= 1'b0; // (RULE6)
			else if (unlock_pulse)
				unlocked_r <= 1'b1; // (RULE3)
		end
	end

	// ==========================================================
	// protected registers; writes while locked are dropped silently
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot0_r <= `PROT_REG0_RESET;
			prot1_r <= `PROT_REG1_RESET;
		end else if (wr.valid && unlocked_r) begin // (RULE2)
			if (paddr == `PROT_REG0_ADDR)
				prot0_r <= pwdata;
			if (paddr == `PROT_REG1_ADDR)
				prot1_r <= pwdata;
		end
	end

	// ==========================================================
	// read data registered in setup phase so prdata is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end else if (psel && !penable) begin
			slverr_r <= !mapped(paddr);
			rdata_r <= 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					`LOCK_CTRL_ADDR: rdata_r[`UNLOCKED_BIT] <= unlocked_r; // (RULE5)
					`PROT_REG0_ADDR: rdata_r <= prot0_r;
					`PROT_REG1_ADDR: rdata_r <= prot1_r;
					default: rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign prdata = rdata_r;
	assign pready = pready_r;
	assign pslverr = slverr_r;
	assign unlocked = unlocked_r;
	assign prot_reg0 = prot0_r;
	assign prot_reg1 = prot1_r;
endmodule

`default_nettype wire

// file: tb/lock_checker.sv
`default_nettype none
module lock_checker(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic unlocked,
	input wire logic [31:0] prot_reg0
);
	// ====
	// gate rules
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire w = psel && penable && pwrite;
	wire lk = paddr == 32'h5000_0100;
	sequence k(b); w && lk && pwdata[7:0] == b; endsequence
	chk_rst_lock: assert property ($rose(presetn) |-> !unlocked) else $error("open");
	chk_prot_hold: assert property (!unlocked |=> $stable(prot_reg0)) else $error("prot");
	chk_key_open: assert property (!unlocked ##0 k(8'h59) ##[2:3] k(8'h16) ##[2:3] k(8'h88) |=> unlocked)
		else $error("key");
	chk_addr_abort: assert property (k(8'h59) ##[2:3] (w && !lk) ##[2:3] k(8'h16) ##[2:3] k(8'h88) |=> !unlocked)
		else $error("abort");
	chk_stay_shut: assert property (!unlocked && !(w && lk && pwdata[7:0] == 8'h88) |=> !unlocked)
		else $error("shut");
	chk_relock: assert property (unlocked && w && lk |=> !unlocked) else $error("relock");
	chk_status: assert property (psel && !penable && !pwrite && lk |=> prdata == {31'h0, unlocked})
		else $error("status");
endmodule
bind register_write_protection_lock lock_checker c_u(.*);
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic wr = 1'h1, rd = 1'h0;
	localparam logic [31:0] lk = 32'h5000_0100, pr = 32'h5000_0104;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, unlocked, e;
	logic [31:0] paddr = 0, pwdata = 0, prdata, prot_reg0, prot_reg1, r;
	int error_cnt = 0, n_compared = 0;
	register_write_protection_lock dut_u(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .unlocked, .prot_reg0, .prot_reg1);
	initial forever #10 pclk = ~pclk;
	// ====
	// bus and checks
	task xf(input logic w, input logic [31:0] a, d);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk) penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		// idle edge keeps psel from being driven twice in one step
		{r, e, psel, penable} <= {prdata, pslverr, 2'h0};
		@(posedge pclk);
	endtask
	task ck(input logic [31:0] g, x);
		n_compared++;
		if (g !== x) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h", $time, g);
		end
	endtask
	task keys(input logic [7:0] m);
		xf(wr, lk, 32'h59);
		xf(wr, lk, {24'h0, m});
		xf(wr, lk, 32'h88);
	endtask
	task close_out;
		$display("errors %0d compares %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task s_reset;
		ck(unlocked, 32'h0);
		ck(pready, 32'h1);
		xf(wr, pr, 32'h5a);
		ck(prot_reg0, 32'h0);
		xf(rd, pr, 32'h0);
		ck(r, 32'h0);
		xf(rd, 32'h5000_0200, 32'h0);
		ck(e, 32'h1);
	endtask
	task s_keys;
		xf(wr, lk, 32'h59);
		xf(wr, pr, 32'h0);
		xf(wr, lk, 32'h16);
		xf(wr, lk, 32'h88);
		ck(unlocked, 32'h0);
		keys(8'h17);
		ck(unlocked, 32'h0);
		keys(8'h16);
		ck(unlocked, 32'h1);
		xf(rd, lk, 32'h0);
		ck(r, 32'h1);
		xf(wr, pr, 32'h5a);
		ck(prot_reg0, 32'h5a);
		xf(wr, 32'h5000_0108, 32'ha5);
		ck(prot_reg1, 32'ha5);
		xf(rd, pr, 32'h0);
		ck(r, 32'h5a);
		xf(wr, lk, 32'h59);
		ck(unlocked, 32'h0);
		xf(rd, lk, 32'h0);
		ck(r, 32'h0);
		xf(wr, lk, 32'h16);
		xf(wr, lk, 32'h88);
		ck(unlocked, 32'h0);
		xf(wr, lk, 32'h59);
		keys(8'h16);
		ck(unlocked, 32'h1);
		xf(wr, lk, 32'h0);
		ck(unlocked, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		s_reset;
		s_keys;
		close_out;
	end
	initial begin
		#20000;
		error_cnt++;
		close_out;
	end
endmodule
`default_nettype wire
